// ### bench/ccj_link_model.sv
// Partner: host link controller driving bit clock and frame sync
`timescale 1ns/1ps
module ccj_link_model
#(
   parameter int FRAME_BITS = 256
)
(
   output logic bit_clk,
   output logic frame_sync
);
   int cnt = 0;
   initial bit_clk = 1'h0;
   // Bit clock runs free at 400 ns so the codec can find its edges
   always #200 bit_clk = ~bit_clk;
   // Frame length equal in both slot modes, sync high for one slot
   always @(posedge bit_clk) cnt <= (cnt + 1) % FRAME_BITS;
   assign frame_sync = (cnt < 16);
endmodule

// ### bench/ccj_regs_chk.sv
// Checker: access answers and output relations of the register bank
`timescale 1ns/1ps
module ccj_regs_chk
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reg_rd,
   input wire logic [3:0] codec_id,
   input wire logic [3:0] access_mask,
   input wire logic reg_rvalid,
   input wire logic [15:0] reg_rdata,
   input wire logic [4:0] slots_per_frame,
   input wire logic spdif_underrun,
   input wire logic spdif_sample_valid,
   input wire logic [19:0] spdif_out,
   input wire logic [1:0] line_in_source,
   input wire logic surround_oe_n,
   input wire logic [2:0] boost_src,
   input wire logic center_lfe_oe_n,
   input wire logic mic_boost_on,
   input wire logic [5:0] boost_gain_db,
   input wire logic frame_start
);
   // ---------------------------------------------------------------
   // Relations
   // ---------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic hit;
   // Codec taken only when the host mask names it
   assign hit = (access_mask & codec_id) != 4'h0;
   read_answer_a:
      assert property (reg_rd && hit |=> reg_rvalid) else $error("read not answered");
   read_refused_a:
      assert property (!hit |=> !reg_rvalid) else $error("foreign read answered");
   rdata_idle_a:
      assert property (!reg_rvalid |-> reg_rdata == 16'h0000) else $error("stale read data");
   slot_count_a:
      assert property (slots_per_frame inside {5'h0D, 5'h10}) else $error("bad slot count");
   underrun_fill_a:
      assert property (spdif_underrun && !spdif_sample_valid |=>
         spdif_out == ccj_pkg::MIDSCALE || $stable(spdif_out)) else $error("bad underrun fill");
   surr_tristate_a:
      assert property (line_in_source == 2'h1 |-> surround_oe_n) else $error("surround driven");
   clfe_tristate_a:
      assert property (boost_src[2] |-> center_lfe_oe_n) else $error("center lfe driven");
   boost_off_a:
      assert property (!mic_boost_on |-> boost_gain_db == ccj_pkg::GAIN_0DB) else $error("gain");
   frame_pulse_a:
      assert property (frame_start |=> !frame_start) else $error("frame start too long");
   cover property (reg_rd && !hit);
   cover property (spdif_underrun);
   cover property (line_in_source == 2'h1);
endmodule
bind ccj_regs ccj_regs_chk u_chk (.*);

// ### bench/codec_config_jack_sense_regs_tb_top.sv
// Testbench: register sequences with expected values
`timescale 1ns/1ps
module codec_config_jack_sense_regs_tb_top;
   logic sys_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, bit_clk, frame_sync;
   logic [3:0] codec_id = 4'h1, access_mask = 4'h1;
   logic [6:0] reg_addr = 7'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [5:0] jack_pin = 6'h00, boost_gain_db;
   logic jack_low_event = 1'h0, mic_boost_on = 1'h0, mic_mix_enable = 1'h0, reg_rvalid;
   logic detect_resistor = 1'h0, spread_jack_gate = 1'h0, downmix_jack_gate = 1'h0;
   logic spdif_underrun = 1'h0, spdif_sample_valid = 1'h0, dac_sample_valid = 1'h0;
   logic dac_starved = 1'h0, spdif_enable, two_ch_stereo, rates_locked, surround_amp_source;
   logic [19:0] spdif_link_sample = 20'h12345, spdif_adc_sample = 20'h54321;
   logic [19:0] dac_sample = 20'h0ABCD, adc_left = 20'h11111, adc_right = 20'h22222;
   logic [19:0] center_in = 20'h33333, lfe_in = 20'h44444;
   logic [19:0] spdif_out, dac_out, center_pin_out, lfe_pin_out;
   logic spread_active, center_lfe_oe_n, surround_oe_n, irq_slot12, irq_slot6, frame_start;
   logic [1:0] loopback_path_select, line_in_source, downmix_active;
   logic [2:0] boost_src;
   logic [4:0] slots_per_frame;
   int err_count = 0, checks = 0, n;
   // ---------------------------------------------------------------
   // Clock, partner, device
   // ---------------------------------------------------------------
   always #25 sys_clk = ~sys_clk;
   ccj_link_model u_link (.bit_clk(bit_clk), .frame_sync(frame_sync));
   ccj_regs u_dut (.*);
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge sys_clk);
      reg_wr = 1'h0;
   endtask
   // Answer stands one cycle, so it is looked at on the next falling edge
   task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic v);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge sys_clk);
      reg_rd = 1'h0;
      chk(reg_rvalid, v);
      chk(reg_rdata, e);
   endtask
   task automatic give_verdict();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (8) @(negedge sys_clk);
      rst_n = 1'h1;
      rd(7'h74, 16'h1001, 1'h1);
      rd(7'h76, 16'h6010, 1'h1);
      rd(7'h78, 16'h0000, 1'h1);
      chk(rates_locked, 1'h0);
      chk(slots_per_frame, 5'h0D);
      chk(boost_gain_db, ccj_pkg::GAIN_0DB);
      mic_boost_on = 1'h1;
      wr(7'h76, 16'hFFFF);
      chk({surround_oe_n, center_lfe_oe_n}, 2'h3);
      chk({spread_active, surround_amp_source}, 2'h3);
      chk({two_ch_stereo, downmix_active}, 3'h7);
      rd(7'h76, 16'hFBFF, 1'h1);
      wr(7'h76, 16'h0005);
      chk(boost_gain_db, ccj_pkg::GAIN_10DB);
      chk({surround_oe_n, line_in_source, rates_locked}, 4'hB);
      wr(7'h76, 16'h0002);
      chk(boost_gain_db, ccj_pkg::GAIN_30DB);
      chk(surround_oe_n, 1'h0);
      dac_sample_valid = 1'h1;
      @(negedge sys_clk);
      {dac_sample_valid, dac_starved} = 2'h1;
      @(negedge sys_clk);
      chk(dac_out, dac_sample);
      wr(7'h76, 16'h8002);
      @(negedge sys_clk);
      chk(dac_out, 20'h00000);
      dac_starved = 1'h0;
      access_mask = 4'h2;
      wr(7'h74, 16'h9000);
      rd(7'h74, 16'h0000, 1'h0);
      access_mask = 4'h1;
      rd(7'h74, 16'h1001, 1'h1);
      rd(7'h7A, 16'h0000, 1'h1);
      wr(7'h74, 16'h94CF);
      @(negedge sys_clk);
      chk(slots_per_frame, 5'h10);
      chk(center_pin_out, adc_right);
      chk(lfe_pin_out, adc_left);
      chk({spdif_enable, loopback_path_select}, 3'h6);
      chk({boost_src, center_lfe_oe_n}, 4'hB);
      spdif_underrun = 1'h1;
      @(negedge sys_clk);
      chk(spdif_out, ccj_pkg::MIDSCALE);
      {spdif_underrun, spdif_sample_valid} = 2'h1;
      @(negedge sys_clk);
      spdif_sample_valid = 1'h0;
      chk(spdif_out, spdif_adc_sample);
      wr(7'h74, 16'h1001);
      spdif_sample_valid = 1'h1;
      @(negedge sys_clk);
      spdif_sample_valid = 1'h0;
      spdif_underrun = 1'h1;
      repeat (2) @(negedge sys_clk);
      chk(spdif_out, 20'h12345);
      spdif_underrun = 1'h0;
      jack_pin = 6'h04;
      for (n = 0; n < 100 && irq_slot12 !== 1'h1; n++) @(negedge sys_clk);
      chk(irq_slot12, 1'h1);
      rd(7'h78, 16'h0300, 1'h1);
      wr(7'h78, 16'h0000);
      rd(7'h78, 16'h0200, 1'h1);
      chk(irq_slot12, 1'h0);
      wr(7'h78, 16'h0180);
      chk({irq_slot6, irq_slot12}, 2'h2);
      jack_low_event = 1'h1;
      @(negedge sys_clk);
      chk({irq_slot6, irq_slot12}, 2'h3);
      give_verdict();
   end
endmodule

// ### hw/ccj_jack_filter.sv
// Module: jack sense synchroniser, stability filter and change detector
`timescale 1ns/1ps
module ccj_jack_filter
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [5:0] jack_pin,
   ccj_jack_if.filt jk
);
   // ---------------------------------------------------------------
   // Per-jack filter
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < ccj_pkg::JACK_COUNT; g++)
      begin : gen_jack
         logic sync_a;
         logic sync_b;
         logic stable;
         logic [4:0] cnt;
         logic next_stable;
         logic [4:0] next_cnt;
         logic pulse;
         logic next_pulse;
         // Count until the synced level has held long enough
         always_comb
         begin
            next_stable = stable;
            next_cnt = 5'h00;
            next_pulse = 1'b0;
            if (sync_b != stable)
            begin
               if (cnt == 5'(ccj_pkg::DEBOUNCE_CYC - 1))
               begin
                  next_stable = sync_b;
                  next_pulse = 1'b1;
               end
               else
               begin
                  next_cnt = cnt + 5'h01;
               end
            end
         end
         // Two flops before logic; only sync_b is looked at
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync_a <= 1'b0;
               sync_b <= 1'b0;
               stable <= 1'b0;
               cnt <= 5'h00;
               pulse <= 1'b0;
            end
            else
            begin
               sync_a <= jack_pin[g];
               sync_b <= sync_a;
               stable <= next_stable;
               cnt <= next_cnt;
               pulse <= next_pulse;
            end
         end
         assign jk.state[g] = stable;
         assign jk.change[g] = pulse;
      end
   endgenerate
endmodule

// ### hw/ccj_jack_if.sv
// Interface: jack sense state and event pulses between filter and register core
`timescale 1ns/1ps
interface ccj_jack_if;
   logic [5:0] state;
   logic [5:0] change;
   modport filt (output state, output change);
   modport core (input state, input change);
endinterface

// ### hw/ccj_link_port.sv
// Module: samples the link bit clock and frame sync, reports edges and slot count
`timescale 1ns/1ps
module ccj_link_port
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic bit_clk,
   input wire logic frame_sync,
   input wire logic wide_slot_mode,
   output logic bit_rise,
   output logic frame_start,
   output logic [4:0] slots_per_frame
);
   // ---------------------------------------------------------------
   // Synchronisers and edge detect
   // ---------------------------------------------------------------
   logic [2:0] clk_s;
   logic [2:0] sync_s;
   logic [4:0] next_slots;
   // Edges are found on the second and third flops only
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_s <= 3'h0;
         sync_s <= 3'h0;
         slots_per_frame <= 5'(ccj_pkg::SLOTS_STD);
      end
      else
      begin
         clk_s <= {clk_s[1:0], bit_clk};
         sync_s <= {sync_s[1:0], frame_sync};
         slots_per_frame <= next_slots;
      end
   end
   // Framing follows the slot width bit
   always_comb
   begin
      next_slots = wide_slot_mode ? 5'(ccj_pkg::SLOTS_WIDE) : 5'(ccj_pkg::SLOTS_STD);
   end
   assign bit_rise = clk_s[1] & ~clk_s[2];
   assign frame_start = sync_s[1] & ~sync_s[2] & bit_rise;
endmodule

// ### hw/ccj_pkg.sv
// Package: register offsets, field positions, reset values and timing for the codec config block
package ccj_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_SERIAL_CFG = 7'h74;
   localparam logic [6:0] ADDR_MISC_ONE = 7'h76;
   localparam logic [6:0] ADDR_JACK_SENSE = 7'h78;

   // ---------------------------------------------------------------
   // Reset values and masks
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_SERIAL_CFG = 16'h1001;
   localparam logic [15:0] RST_MISC_ONE = 16'h6010;
   localparam logic [15:0] RST_JACK_SENSE = 16'h0000;
   localparam logic [15:0] MASK_SERIAL_CFG = 16'hFFFF;
   localparam logic [15:0] MASK_MISC_ONE = 16'h9BFF;
   localparam logic [15:0] RO_ONES_MISC_ONE = 16'h6000;

   // ---------------------------------------------------------------
   // Serial configuration fields
   // ---------------------------------------------------------------
   localparam int SC_SPDIF_LINK = 0;
   localparam int SC_UNDERRUN_FILL = 1;
   localparam int SC_SOURCE_SEL = 2;
   localparam int SC_CLFE_SWAP = 3;
   localparam int SC_IRQ_PATH = 4;
   localparam int SC_LOOPBACK_LO = 5;
   localparam int SC_DETECT_OVR = 7;
   localparam int SC_MIC_SEL_LO = 8;
   localparam int SC_MASK_BIT3 = 11;
   localparam int SC_MASK_LO = 12;
   localparam int SC_WIDE_SLOT = 15;

   // ---------------------------------------------------------------
   // Misc control one fields
   // ---------------------------------------------------------------
   localparam int MC_BOOST_LO = 0;
   localparam int MC_LINE_IN_LO = 2;
   localparam int MC_RATE_UNLOCK = 4;
   localparam int MC_SURR_SRC = 5;
   localparam int MC_TWO_CH_MIC = 6;
   localparam int MC_SPREAD = 7;
   localparam int MC_DOWNMIX_LO = 8;
   localparam int MC_CLFE_DIS = 11;
   localparam int MC_SURR_DIS = 12;
   localparam int MC_DAC_FILL = 15;

   // ---------------------------------------------------------------
   // Jack sense fields
   // ---------------------------------------------------------------
   localparam int JS_LOW_IRQ_LO = 0;
   localparam int JS_LOW_ST_LO = 2;
   localparam int JS_LOW_MODE_LO = 4;
   localparam int JS_UPPER_PATH = 7;
   localparam int JS_UPPER_LO = 8;
   localparam int JACK_COUNT = 6;

   // ---------------------------------------------------------------
   // Gains, midscale, timing
   // ---------------------------------------------------------------
   localparam logic [5:0] GAIN_0DB = 6'h00;
   localparam logic [5:0] GAIN_10DB = 6'h0A;
   localparam logic [5:0] GAIN_20DB = 6'h14;
   localparam logic [5:0] GAIN_30DB = 6'h1E;
   localparam logic [19:0] MIDSCALE = 20'h80000;
   localparam int CLK_NS = 50;
   localparam int DEBOUNCE_NS = 800;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLOTS_STD = 13;
   localparam int SLOTS_WIDE = 16;
endpackage

// ### hw/ccj_regs.sv
// Module: codec serial config, misc control and jack sense register bank
`timescale 1ns/1ps
// Contract
// - Underrun fill set sends midscale on the digital-audio stream at underrun.
// - Underrun fill clear resends the last digital-audio sample at underrun.
// - Source bit picks link playback when 0, ADC capture when 1.
// - Swap bit exchanges center and LFE pins when 1.
// - Path bit steers audio interrupt to slot 12 bit 0 or slot 6 valid.
// - Loop-back field picks front, surround or center/LFE from ADC; 11 reserved.
// - Mic selector picks MIC, LINE_IN, C/LFE or their mixes for boost.
// - Four-bit mask decides which chained codec an access applies to.
// - Wide slot bit gives sixteen 16-bit slots per frame; both ends agree.
// - Boost gain 20, 10 or 30 dB only while boost bit set, else 0 dB.
// - Line-in source picks LINE_IN, surround (tristating it) or MIC pins.
// - Rate unlock clear locks all DAC rates to the front rate.
// - Surround amp fed from surround DACs at 0, mixer at 1.
// - Two-channel mic 0 copies left to both; ignored while mic mix set.
// - Spread bit or jack sense spreads two-channel media to six outputs.
// - Down-mix 10 sums C/LFE, 11 also surround; 0x only by jack sense.
// - Surround pins tristate when disabled or used as line-in source.
// - Starved DACs repeat last sample, or zero when fill bit set.
// - Jack flags set on valid change, clear on 0 write, 1 write raises.
// - Audio interrupt is the OR of all jack flags and jack_low_event.
// - Jack state bits four to seven show current detection state.
// - Mode bits gate interrupts for senses two, three; separate upper path bit.
module ccj_regs
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic bit_clk,
   input wire logic frame_sync,
   input wire logic [3:0] codec_id,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [3:0] access_mask,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [5:0] jack_pin,
   input wire logic jack_low_event,
   input wire logic mic_boost_on,
   input wire logic mic_mix_enable,
   input wire logic detect_resistor,
   input wire logic spread_jack_gate,
   input wire logic downmix_jack_gate,
   input wire logic spdif_underrun,
   input wire logic [19:0] spdif_link_sample,
   input wire logic [19:0] spdif_adc_sample,
   input wire logic spdif_sample_valid,
   input wire logic [19:0] dac_sample,
   input wire logic dac_sample_valid,
   input wire logic dac_starved,
   input wire logic [19:0] adc_left,
   input wire logic [19:0] adc_right,
   input wire logic [19:0] center_in,
   input wire logic [19:0] lfe_in,
   output logic [19:0] spdif_out,
   output logic [19:0] dac_out,
   output logic [19:0] center_pin_out,
   output logic [19:0] lfe_pin_out,
   output logic spdif_enable,
   output logic [1:0] loopback_path_select,
   output logic [2:0] boost_src,
   output logic two_ch_stereo,
   output logic [5:0] boost_gain_db,
   output logic [1:0] line_in_source,
   output logic rates_locked,
   output logic surround_amp_source,
   output logic spread_active,
   output logic [1:0] downmix_active,
   output logic center_lfe_oe_n,
   output logic surround_oe_n,
   output logic irq_slot12,
   output logic irq_slot6,
   output logic [4:0] slots_per_frame,
   output logic frame_start
);
   // ---------------------------------------------------------------
   // Sub-blocks
   // ---------------------------------------------------------------
   ccj_jack_if jk ();
   logic bit_rise;
   ccj_jack_filter u_filt
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .jack_pin(jack_pin),
      .jk(jk)
   );
   logic [15:0] serial_configuration;
   logic [15:0] misc_control_one;
   logic [15:0] advanced_jack_sense;
   logic [15:0] next_serial_configuration;
   logic [15:0] next_misc_control_one;
   logic [15:0] next_advanced_jack_sense;
   ccj_link_port u_link
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .bit_clk(bit_clk),
      .frame_sync(frame_sync),
      .wide_slot_mode(serial_configuration[ccj_pkg::SC_WIDE_SLOT]),
      .bit_rise(bit_rise),
      .frame_start(frame_start),
      .slots_per_frame(slots_per_frame)
   );

   // ---------------------------------------------------------------
   // Register access
   // ---------------------------------------------------------------
   logic selected;
   logic [5:0] flags;
   logic [5:0] flag_set;
   logic [5:0] flag_wr;
   logic [5:0] next_flags;
   logic [15:0] next_rdata;
   logic next_rvalid;
   // Access applies only if the host mask names this codec
   assign selected = |(access_mask & codec_id);

   // Jack flag positions: 2,3 at bits 0,1; 4..7 at even upper bits
   always_comb
   begin
      flags = {advanced_jack_sense[14], advanced_jack_sense[12],
               advanced_jack_sense[10], advanced_jack_sense[8],
               advanced_jack_sense[ccj_pkg::JS_LOW_IRQ_LO +: 2]};
      flag_wr = {reg_wdata[14], reg_wdata[12], reg_wdata[10], reg_wdata[8],
                 reg_wdata[1:0]};
      // Low senses only flag in interrupt mode
      flag_set = jk.change & {4'hF,
                 advanced_jack_sense[ccj_pkg::JS_LOW_MODE_LO +: 2]};
      next_flags = flags;
      if (reg_wr && selected && reg_addr == ccj_pkg::ADDR_JACK_SENSE)
      begin
         next_flags = flag_wr;
      end
      // Hardware set wins over a clearing write
      next_flags = next_flags | flag_set;
   end

   // Register next values
   always_comb
   begin
      next_serial_configuration = serial_configuration;
      next_misc_control_one = misc_control_one;
      if (reg_wr && selected && reg_addr == ccj_pkg::ADDR_SERIAL_CFG)
      begin
         next_serial_configuration = reg_wdata & ccj_pkg::MASK_SERIAL_CFG;
      end
      if (reg_wr && selected && reg_addr == ccj_pkg::ADDR_MISC_ONE)
      begin
         next_misc_control_one = (reg_wdata & ccj_pkg::MASK_MISC_ONE) |
                                 ccj_pkg::RO_ONES_MISC_ONE;
      end
      next_advanced_jack_sense = advanced_jack_sense;
      if (reg_wr && selected && reg_addr == ccj_pkg::ADDR_JACK_SENSE)
      begin
         next_advanced_jack_sense[ccj_pkg::JS_LOW_MODE_LO +: 2] = reg_wdata[5:4];
         next_advanced_jack_sense[ccj_pkg::JS_UPPER_PATH] = reg_wdata[7];
      end
      {next_advanced_jack_sense[14], next_advanced_jack_sense[12],
       next_advanced_jack_sense[10], next_advanced_jack_sense[8],
       next_advanced_jack_sense[1:0]} = next_flags;
      // State bits always mirror the filtered detection
      {next_advanced_jack_sense[15], next_advanced_jack_sense[13],
       next_advanced_jack_sense[11], next_advanced_jack_sense[9]} =
         {jk.state[5], jk.state[4], jk.state[3], jk.state[2]};
      next_advanced_jack_sense[ccj_pkg::JS_LOW_ST_LO +: 2] = jk.state[1:0];
      next_advanced_jack_sense[6] = 1'b0;
      next_rvalid = reg_rd && selected;
      case (reg_addr)
         ccj_pkg::ADDR_SERIAL_CFG: next_rdata = serial_configuration;
         ccj_pkg::ADDR_MISC_ONE: next_rdata = misc_control_one;
         ccj_pkg::ADDR_JACK_SENSE: next_rdata = advanced_jack_sense;
         default: next_rdata = 16'h0000; // Unmapped reads as zero
      endcase
      if (!next_rvalid)
      begin
         next_rdata = 16'h0000;
      end
   end
   // Registers; hardware reset clears every field to default
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_configuration <= ccj_pkg::RST_SERIAL_CFG;
         misc_control_one <= ccj_pkg::RST_MISC_ONE;
         advanced_jack_sense <= ccj_pkg::RST_JACK_SENSE;
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         serial_configuration <= next_serial_configuration;
         misc_control_one <= next_misc_control_one;
         advanced_jack_sense <= next_advanced_jack_sense;
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   // ---------------------------------------------------------------
   // Datapath sample handling
   // ---------------------------------------------------------------
   logic [19:0] next_spdif_out;
   logic [19:0] next_dac_out;
   logic [19:0] next_center;
   logic [19:0] next_lfe;
   logic [19:0] lb_center;
   logic [19:0] lb_lfe;
   logic lb_clfe;
   // Loop-back 10 feeds center/LFE from ADC left/right
   assign lb_clfe = serial_configuration[ccj_pkg::SC_LOOPBACK_LO +: 2] == 2'b10;
   always_comb
   begin
      lb_center = lb_clfe ? adc_left : center_in;
      lb_lfe = lb_clfe ? adc_right : lfe_in;
      next_spdif_out = spdif_out;
      if (spdif_underrun)
      begin
         // Fill 1 forces midscale, fill 0 holds the last sample
         next_spdif_out = serial_configuration[ccj_pkg::SC_UNDERRUN_FILL] ?
                          ccj_pkg::MIDSCALE : spdif_out;
      end
      else if (spdif_sample_valid)
      begin
         next_spdif_out = serial_configuration[ccj_pkg::SC_SOURCE_SEL] ?
                          spdif_adc_sample : spdif_link_sample;
      end
      next_dac_out = dac_out;
      if (dac_starved)
      begin
         // Repeat is free: the register simply holds
         next_dac_out = misc_control_one[ccj_pkg::MC_DAC_FILL] ? 20'h00000 : dac_out;
      end
      else if (dac_sample_valid)
      begin
         next_dac_out = dac_sample;
      end
      next_center = serial_configuration[ccj_pkg::SC_CLFE_SWAP] ? lb_lfe : lb_center;
      next_lfe = serial_configuration[ccj_pkg::SC_CLFE_SWAP] ? lb_center : lb_lfe;
   end
   // Sample registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         spdif_out <= 20'h00000;
         dac_out <= 20'h00000;
         center_pin_out <= 20'h00000;
         lfe_pin_out <= 20'h00000;
      end
      else
      begin
         spdif_out <= next_spdif_out;
         dac_out <= next_dac_out;
         center_pin_out <= next_center;
         lfe_pin_out <= next_lfe;
      end
   end

   // ---------------------------------------------------------------
   // Control decode
   // ---------------------------------------------------------------
   logic [2:0] mic_sel;
   logic [1:0] gain_code;
   logic low_irq;
   logic upper_irq;
   assign mic_sel = serial_configuration[ccj_pkg::SC_MIC_SEL_LO +: 3];
   assign gain_code = misc_control_one[ccj_pkg::MC_BOOST_LO +: 2];
   assign spdif_enable = serial_configuration[ccj_pkg::SC_DETECT_OVR] | detect_resistor;
   assign loopback_path_select = serial_configuration[ccj_pkg::SC_LOOPBACK_LO +: 2];
   // Boost source bits: {C/LFE, LINE_IN, MIC}
   always_comb
   begin
      case (mic_sel)
         3'h0: boost_src = 3'h1;
         3'h1: boost_src = 3'h2;
         3'h2, 3'h3: boost_src = 3'h4;
         3'h4: boost_src = 3'h5;
         3'h5: boost_src = 3'h3;
         3'h6: boost_src = 3'h6;
         default: boost_src = 3'h7;
      endcase
      // Reserved code 11 leaves gain at 0 dB
      case (gain_code)
         2'h0: boost_gain_db = GAIN_SEL(ccj_pkg::GAIN_20DB);
         2'h1: boost_gain_db = GAIN_SEL(ccj_pkg::GAIN_10DB);
         2'h2: boost_gain_db = GAIN_SEL(ccj_pkg::GAIN_30DB);
         default: boost_gain_db = ccj_pkg::GAIN_0DB;
      endcase
   end
   function automatic logic [5:0] GAIN_SEL(input logic [5:0] g);
      GAIN_SEL = mic_boost_on ? g : ccj_pkg::GAIN_0DB;
   endfunction
   assign two_ch_stereo = misc_control_one[ccj_pkg::MC_TWO_CH_MIC] & ~mic_mix_enable;
   assign line_in_source = misc_control_one[ccj_pkg::MC_LINE_IN_LO +: 2];
   assign rates_locked = ~misc_control_one[ccj_pkg::MC_RATE_UNLOCK];
   assign surround_amp_source = misc_control_one[ccj_pkg::MC_SURR_SRC];
   assign spread_active = misc_control_one[ccj_pkg::MC_SPREAD] | spread_jack_gate;
   // Jack gate alone activates the fuller 6-to-2 mix
   assign downmix_active = misc_control_one[ccj_pkg::MC_DOWNMIX_LO + 1] ?
                           misc_control_one[ccj_pkg::MC_DOWNMIX_LO +: 2] :
                           (downmix_jack_gate ? 2'b11 : 2'b00);
   // Enables low while driving; pins go Hi-Z when used as inputs
   assign center_lfe_oe_n = misc_control_one[ccj_pkg::MC_CLFE_DIS] | boost_src[2];
   assign surround_oe_n = misc_control_one[ccj_pkg::MC_SURR_DIS] |
                          (line_in_source == 2'b01);
   // Interrupt steering; path bits never raise one on their own
   assign low_irq = (|flags[1:0]) | jack_low_event;
   assign upper_irq = |flags[5:2];
   always_comb
   begin
      irq_slot12 = 1'b0;
      irq_slot6 = 1'b0;
      if (serial_configuration[ccj_pkg::SC_IRQ_PATH])
      begin
         irq_slot6 = low_irq;
      end
      else
      begin
         irq_slot12 = low_irq;
      end
      if (advanced_jack_sense[ccj_pkg::JS_UPPER_PATH])
      begin
         irq_slot6 = irq_slot6 | upper_irq;
      end
      else
      begin
         irq_slot12 = irq_slot12 | upper_irq;
      end
   end
endmodule
